// *** rtl/mftm_defines.vh ***
// Constants for the low multifunction terminal router: register offsets,
// field positions, reset values and selector codes.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef MFTM_DEFINES_VH
`define MFTM_DEFINES_VH

// Register word offsets (byte address bits 7:2)
`define MFTM_ADDR_ROUTING 6'h00
`define MFTM_ADDR_GPO 6'h01
`define MFTM_ADDR_STATUS 6'h02

// Routing register selector fields
`define MFTM_SEL2_MSB 11
`define MFTM_SEL2_LSB 8
`define MFTM_SEL1_MSB 7
`define MFTM_SEL1_LSB 4
`define MFTM_SEL0_MSB 3
`define MFTM_SEL0_LSB 0
`define MFTM_ROUTING_RESET 12'h000

// General-purpose output register
`define MFTM_GPO_RESET 3'h0

// Status register fields
`define MFTM_STAT_LEVEL_LSB 0
`define MFTM_STAT_SERIAL_BIT 3
`define MFTM_STAT_DRIVE_LSB 4

// Strap timing: count value at which the synchronised straps are valid
`define MFTM_STRAP_WAIT 2'h2

// Selector codes
`define MFTM_CODE_GPI 4'h0
`define MFTM_CODE_GPO 4'h1
`define MFTM_CODE_SPECIAL 4'h2
`define MFTM_CODE_IRQ3 4'h3
`define MFTM_CODE_IRQ4 4'h4
`define MFTM_CODE_IRQ5 4'h5
`define MFTM_CODE_VSTAT 4'h6
`define MFTM_CODE_VSEL0 4'h7
`define MFTM_CODE_AUDIO 4'h8
`define MFTM_CODE_IRQ9 4'h9
`define MFTM_CODE_IRQ10 4'ha
`define MFTM_CODE_IRQ11 4'hb
`define MFTM_CODE_RING_LED 4'hc
`define MFTM_CODE_IRQ13 4'hd
`define MFTM_CODE_EVENT 4'he
`define MFTM_CODE_LAST 4'hf

`endif

// *** rtl/mftm_router.v ***
// Low multifunction terminal router: routing register, output values,
// status, three terminal drivers and the serial bus override.
// Assumes a classic Wishbone master on MCLK and pins on pads that resolve
// the output enables; internal function signals are synchronous to MCLK.
//
// Operation
// - Three 4-bit read/write selectors in bits 11-8, 7-4, 3-0 route terminals 2,1,0.
// - Selectors reset to 0000, each terminal then a general input of same index.
// - Code 0001 drives the terminal with its general output value.
// - Code 0010 gives DMA request, interrupt 2 or PCI INTA per terminal.
// - Codes 0011 to 0101 drive interrupt lines 3, 4 and 5.
// - Code 0110 outputs video status, code 0111 video select zero.
// - Code 1000 outputs the card audio pwm signal.
// - Code 1110 outputs the general event signal for wake.
// - Codes 1001 to 1011 drive interrupt lines 9, 10 and 11.
// - Code 1111 gives interrupt 7 on terminal 2, interrupt 15 elsewhere.
// - Serial bus mode makes terminal 1 the serial data line.
// - Serial bus mode makes terminal 4 the serial clock line.
`timescale 1ns/1ps
`include "mftm_defines.vh"
module mftm_router (
  MCLK,
  RESETN,
  ADR_I,
  DAT_I,
  DAT_O,
  WE_I,
  SEL_I,
  STB_I,
  CYC_I,
  ACK_O,
  IRQ_REQ,
  CENTRAL_DMA_REQUEST,
  PCI_INTA,
  VIDEO_PORT_STATUS,
  VIDEO_PORT_SELECT_ZERO,
  CARD_AUDIO_PWM_OUT,
  GENERAL_EVENT_OUT,
  RING_INDICATE_OUT,
  SOCKET_ACTIVITY_LED,
  POWER_SWITCH_CTL_ZERO,
  POWER_SWITCH_CTL_ONE,
  SERIAL_DATA_OE,
  SERIAL_CLOCK_OE,
  SERIAL_DATA_IN,
  SERIAL_CLOCK_IN,
  SERIAL_MODE,
  MULTI_TERMINAL_PIN_IN,
  MULTI_TERMINAL_PIN_OUT,
  MULTI_TERMINAL_PIN_OE,
  MULTI_TERMINAL_FOUR_PIN_IN,
  MULTI_TERMINAL_FOUR_PIN_OUT,
  MULTI_TERMINAL_FOUR_PIN_OE
);
  input wire MCLK;
  input wire RESETN;
  input wire [7:0] ADR_I;
  input wire [31:0] DAT_I;
  output reg [31:0] DAT_O;
  input wire WE_I;
  input wire [3:0] SEL_I;
  input wire STB_I;
  input wire CYC_I;
  output reg ACK_O;
  input wire [15:0] IRQ_REQ;
  input wire CENTRAL_DMA_REQUEST;
  input wire PCI_INTA;
  input wire VIDEO_PORT_STATUS;
  input wire VIDEO_PORT_SELECT_ZERO;
  input wire CARD_AUDIO_PWM_OUT;
  input wire GENERAL_EVENT_OUT;
  input wire RING_INDICATE_OUT;
  input wire SOCKET_ACTIVITY_LED;
  input wire POWER_SWITCH_CTL_ZERO;
  input wire POWER_SWITCH_CTL_ONE;
  input wire SERIAL_DATA_OE;
  input wire SERIAL_CLOCK_OE;
  output reg SERIAL_DATA_IN;
  output reg SERIAL_CLOCK_IN;
  output reg SERIAL_MODE;
  input wire [2:0] MULTI_TERMINAL_PIN_IN;
  output reg [2:0] MULTI_TERMINAL_PIN_OUT;
  output reg [2:0] MULTI_TERMINAL_PIN_OE;
  input wire MULTI_TERMINAL_FOUR_PIN_IN;
  output reg MULTI_TERMINAL_FOUR_PIN_OUT;
  output reg MULTI_TERMINAL_FOUR_PIN_OE;

  reg [11:0] routing_reg;
  reg [2:0] gpo_reg;
  reg [1:0] strap_cnt_reg;
  wire strap_done;
  wire [3:0] multi_terminal_two_select;
  wire [3:0] multi_terminal_one_select;
  wire [3:0] multi_terminal_zero_select;
  wire [11:0] select_bus;
  wire [2:0] general_input;
  wire general_input_four;
  wire [1:0] power_switch_sync;
  wire [2:0] sel_lvl;
  wire [2:0] sel_en;
  wire bus_req;
  wire bus_write;
  wire [5:0] word_addr;
  reg [31:0] read_data;
  reg [2:0] pin_out_next;
  reg [2:0] pin_oe_next;

  assign multi_terminal_two_select = routing_reg[`MFTM_SEL2_MSB:`MFTM_SEL2_LSB];
  assign multi_terminal_one_select = routing_reg[`MFTM_SEL1_MSB:`MFTM_SEL1_LSB];
  assign multi_terminal_zero_select = routing_reg[`MFTM_SEL0_MSB:`MFTM_SEL0_LSB];
  assign select_bus = {multi_terminal_two_select, multi_terminal_one_select,
                       multi_terminal_zero_select};

  // Pin levels pass two flops before use
  mftm_sync #(
    .W(4)
  ) u_pin_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .d({MULTI_TERMINAL_FOUR_PIN_IN, MULTI_TERMINAL_PIN_IN}),
    .q({general_input_four, general_input})
  );

  mftm_sync #(
    .W(2)
  ) u_strap_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .d({POWER_SWITCH_CTL_ONE, POWER_SWITCH_CTL_ZERO}),
    .q(power_switch_sync)
  );

  // Sync flops leave reset at zero, so the straps are only valid at the third edge
  assign strap_done = (strap_cnt_reg == 2'h3);

  // serial mode caught once after reset
  always @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      strap_cnt_reg <= 2'h0;
      SERIAL_MODE <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `MFTM_STRAP_WAIT)
        SERIAL_MODE <= power_switch_sync[0] & power_switch_sync[1];
    end
  end

  genvar t;
  generate
    for (t = 0; t < 3; t = t + 1)
    begin : g_term
      mftm_term_sel #(
        .TERM(t)
      ) u_sel (
        .sel(select_bus[4*t+3:4*t]),
        .gpo(gpo_reg[t]),
        .irq(IRQ_REQ),
        .dma_req(CENTRAL_DMA_REQUEST),
        .inta(PCI_INTA),
        .vstat(VIDEO_PORT_STATUS),
        .vsel0(VIDEO_PORT_SELECT_ZERO),
        .audio_pwm(CARD_AUDIO_PWM_OUT),
        .event_out(GENERAL_EVENT_OUT),
        .ring(RING_INDICATE_OUT),
        .led(SOCKET_ACTIVITY_LED),
        .out_lvl(sel_lvl[t]),
        .out_en(sel_en[t])
      );
    end
  endgenerate

  // Serial data overrides terminal 1; open drain pulls low only
  always @*
  begin
    pin_out_next = sel_lvl;
    pin_oe_next = sel_en;
    if (SERIAL_MODE)
    begin
      pin_out_next[1] = 1'b0;
      pin_oe_next[1] = SERIAL_DATA_OE;
    end
  end

  // drive for outputs, release for inputs
  always @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      MULTI_TERMINAL_PIN_OUT <= 3'h0;
      MULTI_TERMINAL_PIN_OE <= 3'h0;
      MULTI_TERMINAL_FOUR_PIN_OUT <= 1'b0;
      MULTI_TERMINAL_FOUR_PIN_OE <= 1'b0;
      SERIAL_DATA_IN <= 1'b1;
      SERIAL_CLOCK_IN <= 1'b1;
    end
    else
    begin
      MULTI_TERMINAL_PIN_OUT <= pin_out_next;
      MULTI_TERMINAL_PIN_OE <= pin_oe_next;
      MULTI_TERMINAL_FOUR_PIN_OUT <= 1'b0;
      MULTI_TERMINAL_FOUR_PIN_OE <= SERIAL_MODE & SERIAL_CLOCK_OE;
      // Line levels stay idle high until the pin sync has settled
      if (strap_done)
      begin
        SERIAL_DATA_IN <= general_input[1];
        SERIAL_CLOCK_IN <= general_input_four;
      end
    end
  end

  // Wishbone slave, one wait state, unmapped words read zero
  assign bus_req = CYC_I & STB_I & ~ACK_O;
  assign bus_write = bus_req & WE_I;
  assign word_addr = ADR_I[7:2];

  always @*
  begin
    read_data = 32'h0000_0000;
    case (word_addr)
      `MFTM_ADDR_ROUTING: read_data[11:0] = routing_reg;
      `MFTM_ADDR_GPO: read_data[2:0] = gpo_reg;
      `MFTM_ADDR_STATUS:
      begin
        read_data[`MFTM_STAT_LEVEL_LSB+2:`MFTM_STAT_LEVEL_LSB] = general_input;
        read_data[`MFTM_STAT_SERIAL_BIT] = SERIAL_MODE;
        read_data[`MFTM_STAT_DRIVE_LSB+2:`MFTM_STAT_DRIVE_LSB] = MULTI_TERMINAL_PIN_OE;
      end
      default: read_data = 32'h0000_0000;
    endcase
  end

  always @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
      routing_reg <= `MFTM_ROUTING_RESET;
      gpo_reg <= `MFTM_GPO_RESET;
    end
    else
    begin
      ACK_O <= bus_req;
      DAT_O <= bus_req ? read_data : 32'h0000_0000;
      if (bus_write && word_addr == `MFTM_ADDR_ROUTING)
      begin
        if (SEL_I[0])
          routing_reg[7:0] <= DAT_I[7:0];
        if (SEL_I[1])
          routing_reg[11:8] <= DAT_I[11:8];
      end
      if (bus_write && word_addr == `MFTM_ADDR_GPO && SEL_I[0])
        gpo_reg <= DAT_I[2:0];
    end
  end
endmodule // mftm_router

// *** rtl/mftm_sync.v ***
// Two-flop synchroniser for levels arriving from pins.
// Assumes the inputs are quasi-static relative to MCLK.
`timescale 1ns/1ps
module mftm_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // mftm_sync

// *** rtl/mftm_term_sel.v ***
// Function selector for one multifunction terminal: maps a 4-bit code to
// an output level and a drive enable. Purely combinational.
// Assumes the internal function signals are synchronous to MCLK.
`timescale 1ns/1ps
`include "mftm_defines.vh"
module mftm_term_sel #(
  parameter TERM = 0
) (
  input wire [3:0] sel,
  input wire gpo,
  input wire [15:0] irq,
  input wire dma_req,
  input wire inta,
  input wire vstat,
  input wire vsel0,
  input wire audio_pwm,
  input wire event_out,
  input wire ring,
  input wire led,
  output reg out_lvl,
  output reg out_en
);
  always @*
  begin
    out_lvl = 1'b0;
    out_en = 1'b1;
    case (sel)
      `MFTM_CODE_GPI: out_en = 1'b0;
      `MFTM_CODE_GPO: out_lvl = gpo;
      `MFTM_CODE_SPECIAL: out_lvl = (TERM == 2) ? dma_req : (TERM == 1) ? irq[2] : inta;
      `MFTM_CODE_IRQ3: out_lvl = irq[3];
      `MFTM_CODE_IRQ4: out_lvl = irq[4];
      `MFTM_CODE_IRQ5: out_lvl = irq[5];
      `MFTM_CODE_VSTAT: out_lvl = vstat;
      `MFTM_CODE_VSEL0: out_lvl = vsel0;
      `MFTM_CODE_AUDIO: out_lvl = audio_pwm;
      `MFTM_CODE_IRQ9: out_lvl = irq[9];
      `MFTM_CODE_IRQ10: out_lvl = irq[10];
      `MFTM_CODE_IRQ11: out_lvl = irq[11];
      `MFTM_CODE_RING_LED:
      begin
        out_lvl = (TERM == 2) ? ring : led;
        out_en = (TERM != 1);
      end
      `MFTM_CODE_IRQ13: out_lvl = irq[13];
      `MFTM_CODE_EVENT: out_lvl = event_out;
      `MFTM_CODE_LAST: out_lvl = (TERM == 2) ? irq[7] : irq[15];
      default: out_en = 1'b0;
    endcase
  end
endmodule // mftm_term_sel

// *** verification/mftm_board_model.sv ***
// Board side of the terminals: pads, pull-ups and the two straps.
// Assumes an enable is high while the router drives the pad.
`timescale 1ns/1ps
module mftm_board_model (
  input wire [2:0] pout,
  input wire [2:0] poe,
  input wire fout,
  input wire foe,
  input wire [2:0] board,
  input wire strap,
  output wire [2:0] pin,
  output wire fin,
  output wire s0,
  output wire s1
);
  // Undriven pads show the board's own level
  assign pin = poe & pout | ~poe & board;
  // Serial clock pad has a pull-up
  assign fin = foe ? fout : 1'b1;
  assign s0 = strap;
  assign s1 = strap;
endmodule // mftm_board_model

// *** verification/mftm_router_monitor.sv ***
// Port checker for the low terminal router, bound to each instance.
// Assumes one MCLK domain and an active-low RESETN.
`timescale 1ns/1ps
module mftm_router_monitor (
  input wire MCLK,
  input wire RESETN,
  input wire [7:0] ADR_I,
  input wire [31:0] DAT_I,
  input wire WE_I,
  input wire [3:0] SEL_I,
  input wire STB_I,
  input wire CYC_I,
  input wire ACK_O,
  input wire [15:0] IRQ_REQ,
  input wire SERIAL_MODE,
  input wire [2:0] MULTI_TERMINAL_PIN_OUT,
  input wire [2:0] MULTI_TERMINAL_PIN_OE,
  input wire MULTI_TERMINAL_FOUR_PIN_OE
);
  wire [2:0] oe = MULTI_TERMINAL_PIN_OE;
  wire [2:0] lv = MULTI_TERMINAL_PIN_OUT;
  reg [11:0] rt_reg;
  wire pick = IRQ_REQ[rt_reg[11:8]];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // Routing word as last written
  always @(posedge MCLK or negedge RESETN)
    if (!RESETN)
      rt_reg <= 12'h000;
    else if (CYC_I && STB_I && !ACK_O && WE_I && ADR_I[7:2] == 6'h00)
    begin
      if (SEL_I[0])
        rt_reg[7:0] <= DAT_I[7:0];
      if (SEL_I[1])
        rt_reg[11:8] <= DAT_I[11:8];
    end
  property p_ack; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; ACK_O |=> !ACK_O; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  property p_in; $past(rt_reg[3:0]) == 4'h0 |-> !oe[0]; endproperty
  a_in: assert property (p_in) else $error("input driven");
  property p_irq;
    $past(rt_reg[11:8]) inside {3, 4, 5, 9, 10, 11, 13} |-> oe[2] && lv[2] == $past(pick);
  endproperty
  a_irq: assert property (p_irq) else $error("irq route");
  property p_irq7; $past(rt_reg[11:8]) == 4'hf |-> lv[2] == $past(IRQ_REQ[7]); endproperty
  a_irq7: assert property (p_irq7) else $error("irq7 route");
  property p_rsv; $past(rt_reg[7:4]) == 4'hc && !SERIAL_MODE |-> !oe[1]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved driven");
  property p_sda; $past(SERIAL_MODE) && SERIAL_MODE |-> !lv[1]; endproperty
  a_sda: assert property (p_sda) else $error("data pin high");
  property p_scl; !$past(SERIAL_MODE) && !SERIAL_MODE |-> !MULTI_TERMINAL_FOUR_PIN_OE; endproperty
  a_scl: assert property (p_scl) else $error("clock pin driven");
  c_wr: cover property (CYC_I && WE_I && ACK_O);
  c_rsv: cover property ($past(rt_reg[7:4]) == 4'hc);
  c_ser: cover property (SERIAL_MODE);
endmodule // mftm_router_monitor

bind mftm_router mftm_router_monitor u_monitor (.*);

// *** verification/tb_multifunction_terminal_mux_low.sv ***
// Bench for the low terminal router: bus checks, code sweep, serial straps.
// Assumes the board model resolves the pads and the checker is bound.
`timescale 1ns/1ps
module tb_multifunction_terminal_mux_low;
  logic MCLK = 0, RESETN = 0, WE_I = 0, STB_I = 0, CYC_I = 0, ACK_O, strap = 0;
  logic [7:0] ADR_I = 8'h00, fn = 8'h00;
  logic [31:0] DAT_I = 32'h0, DAT_O, rd;
  logic [3:0] SEL_I = 4'h0;
  logic [15:0] IRQ_REQ = 16'h0000;
  logic [2:0] MULTI_TERMINAL_PIN_OUT, MULTI_TERMINAL_PIN_OE, board = 3'h5, gpo;
  logic SERIAL_DATA_OE = 0, SERIAL_CLOCK_OE = 0, SERIAL_DATA_IN, SERIAL_CLOCK_IN, SERIAL_MODE;
  logic MULTI_TERMINAL_FOUR_PIN_OUT, MULTI_TERMINAL_FOUR_PIN_OE;
  wire [2:0] MULTI_TERMINAL_PIN_IN;
  wire MULTI_TERMINAL_FOUR_PIN_IN, POWER_SWITCH_CTL_ZERO, POWER_SWITCH_CTL_ONE;
  wire CENTRAL_DMA_REQUEST = fn[0], PCI_INTA = fn[1], VIDEO_PORT_STATUS = fn[2];
  wire VIDEO_PORT_SELECT_ZERO = fn[3], CARD_AUDIO_PWM_OUT = fn[4];
  wire GENERAL_EVENT_OUT = fn[5], RING_INDICATE_OUT = fn[6], SOCKET_ACTIVITY_LED = fn[7];
  int failures = 0, comparisons = 0;
  always #5 MCLK = ~MCLK;
  mftm_router DUT (.*);
  mftm_board_model board_side (.pout(MULTI_TERMINAL_PIN_OUT), .poe(MULTI_TERMINAL_PIN_OE),
    .fout(MULTI_TERMINAL_FOUR_PIN_OUT), .foe(MULTI_TERMINAL_FOUR_PIN_OE), .board(board),
    .strap(strap), .pin(MULTI_TERMINAL_PIN_IN), .fin(MULTI_TERMINAL_FOUR_PIN_IN),
    .s0(POWER_SWITCH_CTL_ZERO), .s1(POWER_SWITCH_CTL_ONE));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Request held until ack is sampled, then dropped for a cycle
  task wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
    CYC_I <= 1;
    STB_I <= 1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= d;
    SEL_I <= s;
    do
      @(posedge MCLK);
    while (ACK_O !== 1'b1);
    rd = DAT_O;
    CYC_I <= 0;
    STB_I <= 0;
    @(posedge MCLK);
  endtask
  // Expected {enable, level} of terminal t under code c
  function logic [1:0] expv(input int t, input logic [3:0] c);
    logic v;
    case (c)
      4'h1: v = gpo[t];
      4'h2: v = t == 2 ? fn[0] : t == 1 ? IRQ_REQ[2] : fn[1];
      4'h6, 4'h7, 4'h8: v = fn[c - 4];
      4'hc: v = fn[t == 2 ? 6 : 7];
      4'he: v = fn[5];
      4'hf: v = IRQ_REQ[t == 2 ? 7 : 15];
      default: v = IRQ_REQ[c];
    endcase
    return (c == 4'h0 || c == 4'hc && t == 1) ? 2'b00 : {1'b1, v};
  endfunction
  task t_defaults;
    wb(8'h00, 32'h0, 0, 4'hf);
    chk(rd, 32'h0);
    wb(8'h08, 32'h0, 0, 4'hf);
    chk(rd, 32'h5);
    wb(8'h3c, 32'hfff, 1, 4'hf);
    wb(8'h3c, 32'h0, 0, 4'hf);
    chk(rd, 32'h0);
  endtask
  task t_codes;
    for (int c = 0; c < 16; c++)
    begin
      wb(8'h00, {20'h0, {3{c[3:0]}}}, 1, 4'hf);
      wb(8'h00, 32'h0, 0, 4'hf);
      chk(rd, {20'h0, {3{c[3:0]}}});
      for (int p = 0; p < 2; p++)
      begin
        IRQ_REQ <= p ? 16'ha5c3 : 16'h5a3c;
        fn <= p ? 8'h5a : 8'ha5;
        gpo = p ? 3'h5 : 3'h2;
        wb(8'h04, {29'h0, gpo}, 1, 4'h1);
        repeat (2) @(posedge MCLK);
        for (int t = 0; t < 3; t++)
          chk({MULTI_TERMINAL_PIN_OE[t], MULTI_TERMINAL_PIN_OE[t] & MULTI_TERMINAL_PIN_OUT[t]},
            expv(t, c[3:0]));
      end
    end
    wb(8'h00, 32'h0, 1, 4'h1);
    wb(8'h00, 32'h0, 0, 4'hf);
    chk(rd, 32'h00000f00);
  endtask
  task t_serial;
    strap <= 1;
    board <= 3'h7;
    RESETN <= 0;
    repeat (20) @(posedge MCLK);
    RESETN <= 1;
    repeat (2) @(posedge MCLK);
    chk({SERIAL_DATA_IN, SERIAL_CLOCK_IN}, 2'b11);
    repeat (3) @(posedge MCLK);
    chk(SERIAL_MODE, 1'b1);
    SERIAL_DATA_OE <= 1;
    SERIAL_CLOCK_OE <= 1;
    repeat (6) @(posedge MCLK);
    chk({MULTI_TERMINAL_PIN_OE[1], MULTI_TERMINAL_PIN_OUT[1], MULTI_TERMINAL_FOUR_PIN_OE,
      MULTI_TERMINAL_FOUR_PIN_OUT, SERIAL_DATA_IN, SERIAL_CLOCK_IN}, 6'b101000);
    SERIAL_DATA_OE <= 0;
    repeat (6) @(posedge MCLK);
    chk({MULTI_TERMINAL_PIN_OE[1], MULTI_TERMINAL_FOUR_PIN_OE, SERIAL_DATA_IN,
      SERIAL_CLOCK_IN}, 4'b0110);
  endtask
  initial
  begin
    repeat (20) @(posedge MCLK);
    RESETN <= 1;
    @(posedge MCLK);
    t_defaults;
    t_codes;
    t_serial;
    give_verdict;
  end
  initial
  begin
    #50000;
    failures++;
    give_verdict;
  end
endmodule // tb_multifunction_terminal_mux_low
